// [ovc_pkg.sv]
// shared constants for the overlay compositor control block
package ovc_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFF_PRI_CTRL   = 16'h8180;
  localparam logic [15:0] OFF_KEY_CTRL   = 16'h8184;
  localparam logic [15:0] OFF_SEC_CTRL   = 16'h8190;
  localparam logic [15:0] OFF_CHROMA_UP  = 16'h8194;
  localparam logic [15:0] OFF_SCALE      = 16'h8198;
  localparam logic [15:0] OFF_BLEND      = 16'h81A0;
  // ---------------------------------------------------------------
  // writable bit masks (reserved bits read zero)
  // ---------------------------------------------------------------
  localparam logic [31:0] MSK_PRI_CTRL   = 32'h7700_0000;
  localparam logic [31:0] MSK_KEY_CTRL   = 32'h17FF_FFFF;
  localparam logic [31:0] MSK_SEC_CTRL   = 32'h7700_0FFF;
  localparam logic [31:0] MSK_CHROMA_UP  = 32'h00FF_FFFF;
  localparam logic [31:0] MSK_SCALE      = 32'h07FF_07FF;
  localparam logic [31:0] MSK_BLEND      = 32'h0700_1C1C;
  localparam logic [31:0] RST_VALUE      = 32'h0000_0000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FMT_LSB   = 24;
  localparam int FILT_LSB  = 28;
  localparam int KSRC_BIT  = 28;
  localparam int KS_LSB    = 2;
  localparam int KP_LSB    = 10;
  localparam int COEF_ONE  = 8;
  localparam int CLAMP_SH  = 3;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] FMT_KRGB16 = 3'h3;
  typedef enum logic [2:0] {
    OVC_SEC_OVER = 3'b000,
    OVC_PRI_OVER = 3'b001,
    OVC_DISSOLVE = 3'b010,
    OVC_FADE     = 3'b011,
    OVC_KEY_PRI  = 3'b101,
    OVC_KEY_SEC  = 3'b110
  } ovc_mode_e;
endpackage

// [ovc_ctrl.sv]
// overlay compositor register file and per-pixel compose datapath
// What this block does
// [R1] registers answer memory-mapped cycles only, not I/O
// [R2] primary format field bits 26-24 decoded
// [R3] primary filter field bits 30-28 decoded
// [R4] key register holds blue, green, red lower keys
// [R5] precision code selects compared top bits
// [R6] key-bit source: pixel key bit picks stream
// [R7] key select one: colour/chroma keying, non-keyed formats
// [R8] software loads accumulator start per width formula
// [R9] secondary format field bits 26-24 decoded
// [R10] secondary filter field bits 30-28 decoded
// [R11] shadowed fields apply at next vertical sync
// [R12] upper bound register holds three chroma limits
// [R13] software sets first scale constant width minus one
// [R14] software sets negative second scale constant
// [R15] control registers clear to zero at reset
// [R16] blend register coefficient and mode field layout
// [R17] composition mode decode of six codes
// [R18] dissolve blends primary and secondary, ignores secondary coef
// [R19] fade weighs each by own coefficient over eight
// [R20] chroma match: every component within bounds inclusive
// [R21] reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
module ovc_ctrl (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        regSel,
  input  wire logic        memSpace,
  input  wire logic        regWr,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic        vsyncPin,
  input  wire logic        pixValid,
  input  wire logic [23:0] priPix,
  input  wire logic        priKey,
  input  wire logic [23:0] secPix,
  input  wire logic        secKey,
  output logic      [23:0] outPix,
  output logic             outValid,
  output logic      [2:0]  priFormat,
  output logic      [2:0]  priFilter,
  output logic      [2:0]  secFormat,
  output logic      [2:0]  secFilter,
  output logic      [11:0] accumStart,
  output logic      [10:0] scaleOne,
  output logic      [10:0] scaleTwo
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic [31:0] pri;
    logic [31:0] key;
    logic [31:0] secW;
    logic [31:0] secA;
    logic [31:0] chr;
    logic [31:0] sclW;
    logic [31:0] sclA;
    logic [31:0] blW;
    logic [31:0] blA;
    logic [31:0] rd;
    logic        vs1;
    logic        vs2;
    logic        vs3;
    logic [23:0] pix;
    logic        val;
  } ovc_state_s;
  ovc_state_s stateQ, stateD;

  // top bits compared at a given precision code
  function automatic logic [7:0] precMask(input logic [2:0] code);
    precMask = 8'hFF << (3'h7 - code);
  endfunction

  function automatic logic [7:0] mixChan(input logic [7:0] a, input logic [7:0] b,
                                         input logic [3:0] ka, input logic [3:0] kb);
    logic [11:0] sum;
    // widen before the product so a full 8-bit channel times eight keeps its top bits
    sum = ({4'h0, a} * {8'h00, ka}) + ({4'h0, b} * {8'h00, kb});
    mixChan = (sum[11:3] > 9'h0FF) ? 8'hFF : sum[10:3];
  endfunction

  logic        wrHit;
  logic [2:0]  mode;
  logic [3:0]  kp;
  logic [3:0]  ks;
  logic        vsRise;
  logic        colMatch;
  logic        chrMatch;
  logic        priShow;
  logic        keyOn;
  logic [7:0]  pm;

  always_comb begin
    stateD = stateQ;
    wrHit  = regSel && memSpace && regWr;  // [R1]
    mode   = stateQ.blA[26:24];  // [R16]
    kp     = {1'b0, stateQ.blA[12:10]};  // [R16]
    ks     = {1'b0, stateQ.blA[4:2]};  // [R16]
    vsRise = stateQ.vs2 && !stateQ.vs3;
    keyOn  = stateQ.key[ovc_pkg::KSRC_BIT];
    pm     = precMask(stateQ.key[26:24]);  // [R5]
    colMatch = ((priPix[23:16] & pm) == (stateQ.key[23:16] & pm)) &&  // [R4]
               ((priPix[15:8] & pm) == (stateQ.key[15:8] & pm)) &&
               ((priPix[7:0] & pm) == (stateQ.key[7:0] & pm));
    chrMatch = 1'b1;  // [R20]
    for (int c = 0; c < 3; c++) begin
      if (secPix[c*8 +: 8] < stateQ.key[c*8 +: 8] ||
          secPix[c*8 +: 8] > stateQ.chr[c*8 +: 8]) begin  // [R12]
        chrMatch = 1'b0;
      end
    end
    // -------------------------------------------------------------
    // register writes, reserved bits dropped
    // -------------------------------------------------------------
    if (wrHit) begin
      case (regAddr)  // [R21]
        ovc_pkg::OFF_PRI_CTRL:  stateD.pri  = regWdata & ovc_pkg::MSK_PRI_CTRL;
        ovc_pkg::OFF_KEY_CTRL:  stateD.key  = regWdata & ovc_pkg::MSK_KEY_CTRL;
        ovc_pkg::OFF_SEC_CTRL:  stateD.secW = regWdata & ovc_pkg::MSK_SEC_CTRL;
        ovc_pkg::OFF_CHROMA_UP: stateD.chr  = regWdata & ovc_pkg::MSK_CHROMA_UP;
        ovc_pkg::OFF_SCALE:     stateD.sclW = regWdata & ovc_pkg::MSK_SCALE;
        ovc_pkg::OFF_BLEND:     stateD.blW  = regWdata & ovc_pkg::MSK_BLEND;
        default: ;
      endcase
    end
    // reads show the written value; shadows move only on vsync
    case (regAddr)
      ovc_pkg::OFF_PRI_CTRL:  stateD.rd = stateQ.pri;
      ovc_pkg::OFF_KEY_CTRL:  stateD.rd = stateQ.key;
      ovc_pkg::OFF_SEC_CTRL:  stateD.rd = stateQ.secW;
      ovc_pkg::OFF_CHROMA_UP: stateD.rd = stateQ.chr;
      ovc_pkg::OFF_SCALE:     stateD.rd = stateQ.sclW;
      ovc_pkg::OFF_BLEND:     stateD.rd = stateQ.blW;
      default:                stateD.rd = ovc_pkg::RST_VALUE;
    endcase
    if (!(regSel && memSpace)) begin
      stateD.rd = ovc_pkg::RST_VALUE;  // [R1]
    end
    // -------------------------------------------------------------
    // vertical sync loads the active copies
    // -------------------------------------------------------------
    stateD.vs1 = vsyncPin;
    stateD.vs2 = stateQ.vs1;
    stateD.vs3 = stateQ.vs2;
    if (vsRise) begin
      stateD.secA = stateQ.secW;  // [R11]
      stateD.sclA = stateQ.sclW;
      stateD.blA  = stateQ.blW;
    end
    // -------------------------------------------------------------
    // compose
    // -------------------------------------------------------------
    priShow = 1'b0;
    case (mode)  // [R17]
      ovc_pkg::OVC_SEC_OVER: priShow = 1'b0;
      ovc_pkg::OVC_PRI_OVER: priShow = 1'b1;
      ovc_pkg::OVC_KEY_PRI: begin
        if (!keyOn && stateQ.pri[26:24] == ovc_pkg::FMT_KRGB16) begin
          priShow = priKey;  // [R6]
        end else if (keyOn && stateQ.pri[26:24] != ovc_pkg::FMT_KRGB16) begin
          priShow = !colMatch;  // [R7]
        end else begin
          priShow = 1'b1;
        end
      end
      ovc_pkg::OVC_KEY_SEC: begin
        if (!keyOn && stateQ.secA[26:24] == ovc_pkg::FMT_KRGB16) begin
          priShow = !secKey;  // [R6]
        end else if (keyOn && stateQ.secA[26:24] != ovc_pkg::FMT_KRGB16) begin
          priShow = chrMatch;  // [R7]
        end else begin
          priShow = 1'b0;
        end
      end
      default: priShow = 1'b1;
    endcase
    stateD.val = pixValid;
    for (int c = 0; c < 3; c++) begin
      if (mode == ovc_pkg::OVC_DISSOLVE) begin
        stateD.pix[c*8 +: 8] = mixChan(priPix[c*8 +: 8], secPix[c*8 +: 8],
                                       kp, 4'(ovc_pkg::COEF_ONE) - kp);  // [R18]
      end else if (mode == ovc_pkg::OVC_FADE) begin
        stateD.pix[c*8 +: 8] = mixChan(priPix[c*8 +: 8], secPix[c*8 +: 8],
                                       kp, ks);  // [R19]
      end else begin
        stateD.pix[c*8 +: 8] = priShow ? priPix[c*8 +: 8] : secPix[c*8 +: 8];
      end
    end
    if (!pixValid) begin
      stateD.pix = stateQ.pix;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= '0;  // [R15]
    end else begin
      stateQ <= stateD;
    end
  end

  // -------------------------------------------------------------
  // outputs, all from flops
  // -------------------------------------------------------------
  assign regRdata   = stateQ.rd;
  assign outPix     = stateQ.pix;
  assign outValid   = stateQ.val;
  assign priFormat  = stateQ.pri[26:24];  // [R2]
  assign priFilter  = stateQ.pri[30:28];  // [R3]
  assign secFormat  = stateQ.secA[26:24];  // [R9]
  assign secFilter  = stateQ.secA[30:28];  // [R10]
  assign accumStart = stateQ.secA[11:0];  // [R8]
  assign scaleOne   = stateQ.sclA[10:0];  // [R13]
  assign scaleTwo   = stateQ.sclA[26:16];  // [R14]

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_io_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R1]
    (regSel && !memSpace && regWr) |=> $stable(stateQ.pri) && $stable(stateQ.blW))
    else $error("io cycle changed a register");
  a_shadow_hold: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R11]
    !vsRise |=> $stable(secFormat) && $stable(scaleOne))
    else $error("shadow changed without vsync");
  a_shadow_load: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R11]
    vsRise |=> stateQ.blA == $past(stateQ.blW))
    else $error("vsync did not load blend");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R21]
    (stateQ.chr[31:24] == 8'h00) && (stateQ.pri[23:0] == 24'h0))
    else $error("reserved bits set");
  a_pri_over: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R17]
    (pixValid && mode == ovc_pkg::OVC_PRI_OVER) |=> outPix == $past(priPix))
    else $error("primary overlay wrong");
  a_sec_over: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R17]
    (pixValid && mode == ovc_pkg::OVC_SEC_OVER) |=> outPix == $past(secPix))
    else $error("secondary overlay wrong");
  a_keybit_pick: assert property (@(posedge core_clk) disable iff (!rst_n)  // [R6]
    (pixValid && mode == ovc_pkg::OVC_KEY_SEC && !keyOn &&
     secFormat == ovc_pkg::FMT_KRGB16 && secKey) |=> outPix == $past(secPix))
    else $error("key bit ignored");
  a_valid_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    pixValid |=> outValid)
    else $error("valid lost");
endmodule
`default_nettype wire

// [ovc_host.sv]
// host processor model issuing register cycles to the compositor
`timescale 1ns/100ps
`default_nettype none
module ovc_host (
  input  wire logic        core_clk,
  input  wire logic [31:0] regRdata,
  output logic             regSel,
  output logic             memSpace,
  output logic             regWr,
  output logic      [15:0] regAddr,
  output logic      [31:0] regWdata
);
  initial begin
    regSel = 1'b0;
    memSpace = 1'b0;
    regWr = 1'b0;
    regAddr = 16'h0000;
    regWdata = 32'h0000_0000;
  end

  // one bus cycle; mem low issues an I/O cycle instead of a memory-mapped one
  task automatic acc(input logic mem, input logic wr, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    regSel <= 1'b1;
    memSpace <= mem;
    regWr <= wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regSel <= 1'b0;
    regWr <= 1'b0;
    // released lines carry garbage so stale values are never mistaken for data
    regAddr <= ~a;
    regWdata <= ~d;
    // registered answer is taken mid-cycle, well away from the edge that moves it
    @(negedge core_clk);
    q = regRdata;
  endtask

  // software computes scaler constants from window widths
  function automatic logic [31:0] scaleWord(input int w0, input int w1);
    return {5'h00, 11'(w0 - w1), 5'h00, 11'(w0 - 1)};
  endfunction

  function automatic logic [11:0] accumVal(input int w0, input int w1);
    return 12'(2 * (w0 - 1) - (w1 - 1));
  endfunction
endmodule
`default_nettype wire

// [ovc_ctrl_bench.sv]
// self-checking bench for the overlay compositor control block
`timescale 1ns/100ps
`default_nettype none
module ovc_ctrl_bench;
  logic        core_clk, rst_n, regSel, memSpace, regWr, vsyncPin, pixValid, priKey, secKey;
  logic        outValid;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, q;
  logic [23:0] priPix, secPix, outPix;
  logic [2:0]  priFormat, priFilter, secFormat, secFilter;
  logic [11:0] accumStart;
  logic [10:0] scaleOne, scaleTwo;
  logic [2:0]  f, fl;
  int          n_mismatch, checks;
  localparam logic [23:0] PRI = 24'h80_40_10;
  localparam logic [23:0] SEC = 24'h20_C0_F8;
  logic [15:0] offs [6] = '{ovc_pkg::OFF_PRI_CTRL, ovc_pkg::OFF_KEY_CTRL, ovc_pkg::OFF_SEC_CTRL,
                            ovc_pkg::OFF_CHROMA_UP, ovc_pkg::OFF_SCALE, ovc_pkg::OFF_BLEND};
  logic [31:0] msks [6] = '{ovc_pkg::MSK_PRI_CTRL, ovc_pkg::MSK_KEY_CTRL, ovc_pkg::MSK_SEC_CTRL,
                            ovc_pkg::MSK_CHROMA_UP, ovc_pkg::MSK_SCALE, ovc_pkg::MSK_BLEND};

  ovc_ctrl i_ovc_ctrl (.core_clk(core_clk), .rst_n(rst_n), .regSel(regSel),
    .memSpace(memSpace), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .vsyncPin(vsyncPin), .pixValid(pixValid), .priPix(priPix),
    .priKey(priKey), .secPix(secPix), .secKey(secKey), .outPix(outPix), .outValid(outValid),
    .priFormat(priFormat), .priFilter(priFilter), .secFormat(secFormat),
    .secFilter(secFilter), .accumStart(accumStart), .scaleOne(scaleOne), .scaleTwo(scaleTwo));
  ovc_host i_ovc_host (.core_clk(core_clk), .regRdata(regRdata), .regSel(regSel),
    .memSpace(memSpace), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chkR(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkP(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t pixel got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_ovc_host.acc(1'b1, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    i_ovc_host.acc(1'b1, 1'b0, a, 32'h0000_0000, q);
    chkR(q, exp);
  endtask
  // pulse long enough to cover the two-flop synchroniser and edge detect
  task automatic vs;
    @(posedge core_clk);
    vsyncPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    vsyncPin <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pix(input logic pk, input logic sk, input logic [23:0] exp);
    @(posedge core_clk);
    priPix <= PRI;
    secPix <= SEC;
    priKey <= pk;
    secKey <= sk;
    pixValid <= 1'b1;
    @(posedge core_clk);
    pixValid <= 1'b0;
    @(negedge core_clk);
    chkP(outPix, exp);
    chkR({31'h0, outValid}, 32'h1);
  endtask
  function automatic logic [23:0] mix(input int a, input int b);
    logic [23:0] r;
    for (int c = 0; c < 3; c++) begin
      r[c*8 +: 8] = 8'((int'(PRI[c*8 +: 8]) * a + int'(SEC[c*8 +: 8]) * b) / 8);
    end
    return r;
  endfunction
  function automatic logic [31:0] blend(input logic [2:0] m, input logic [2:0] kp,
                                        input logic [2:0] ks);
    return {5'h00, m, 11'h000, kp, 5'h00, ks, 2'h0};
  endfunction
  task automatic final_report;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #(4000 * 50);
    n_mismatch++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    vsyncPin = 1'b0;
    pixValid = 1'b0;
    priPix = 24'h00_0000;
    secPix = 24'h00_0000;
    priKey = 1'b0;
    secKey = 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(offs[i], ovc_pkg::RST_VALUE);
    for (int i = 0; i < 6; i++) begin
      i_ovc_host.acc(1'b0, 1'b1, offs[i], 32'hFFFF_FFFF, q);
      rd(offs[i], 32'h0000_0000);
      wr(offs[i], 32'hFFFF_FFFF);
      rd(offs[i], msks[i]);
      i_ovc_host.acc(1'b0, 1'b0, offs[i], 32'h0000_0000, q);
      chkR(q, 32'h0000_0000);
      wr(offs[i], 32'h0000_0000);
    end
    wr(16'h8188, 32'hFFFF_FFFF);
    rd(16'h8188, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      f = 3'(i);
      fl = 3'(i % 3);
      wr(ovc_pkg::OFF_PRI_CTRL, {1'b0, fl, 1'b0, f, 24'h00_0000});
      @(posedge core_clk);
      chkR({26'h0, priFilter, priFormat}, {26'h0, fl, f});
    end
    for (int i = 1; i < 8; i++) begin
      f = 3'(i);
      fl = 3'(i & 3);
      wr(ovc_pkg::OFF_SEC_CTRL, {1'b0, fl, 1'b0, f, 12'h000, i_ovc_host.accumVal(i * 10, i * 20)});
      chkR({26'h0, secFilter, secFormat}, {26'h0, 3'((i - 1) & 3), 3'(i - 1)});
      vs();
      chkR({26'h0, secFilter, secFormat}, {26'h0, fl, f});
      chkR({20'h0, accumStart}, {20'h0, 12'(2 * (i * 10 - 1) - (i * 20 - 1))});
    end
    wr(ovc_pkg::OFF_SCALE, i_ovc_host.scaleWord(100, 300));
    vs();
    chkR({10'h0, scaleTwo, scaleOne}, {10'h0, 11'(-200), 11'(99)});
    wr(ovc_pkg::OFF_PRI_CTRL, 32'h0000_0000);
    wr(ovc_pkg::OFF_BLEND, blend(3'h0, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, SEC);
    wr(ovc_pkg::OFF_BLEND, blend(3'h1, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, PRI);
    wr(ovc_pkg::OFF_BLEND, blend(3'h2, 3'h2, 3'h7));
    vs();
    pix(1'b0, 1'b0, mix(2, 6));
    wr(ovc_pkg::OFF_BLEND, blend(3'h3, 3'h3, 3'h4));
    vs();
    pix(1'b0, 1'b0, mix(3, 4));
    wr(ovc_pkg::OFF_KEY_CTRL, 32'h1000_0000 | {8'h00, 24'h9F_7F_7F});
    wr(ovc_pkg::OFF_BLEND, blend(3'h5, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, SEC);
    wr(ovc_pkg::OFF_KEY_CTRL, 32'h1700_0000 | {8'h00, 24'h9F_7F_7F});
    pix(1'b0, 1'b0, PRI);
    wr(ovc_pkg::OFF_KEY_CTRL, 32'h1000_0000 | {8'h00, SEC});
    wr(ovc_pkg::OFF_CHROMA_UP, {8'h00, SEC});
    wr(ovc_pkg::OFF_SEC_CTRL, 32'h0100_0000);
    wr(ovc_pkg::OFF_BLEND, blend(3'h6, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, PRI);
    wr(ovc_pkg::OFF_CHROMA_UP, {8'h00, SEC - 24'h00_0001});
    pix(1'b0, 1'b0, SEC);
    wr(ovc_pkg::OFF_KEY_CTRL, 32'h0000_0000);
    wr(ovc_pkg::OFF_SEC_CTRL, {5'h00, ovc_pkg::FMT_KRGB16, 24'h00_0000});
    wr(ovc_pkg::OFF_BLEND, blend(3'h6, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, PRI);
    pix(1'b0, 1'b1, SEC);
    wr(ovc_pkg::OFF_PRI_CTRL, {5'h00, ovc_pkg::FMT_KRGB16, 24'h00_0000});
    wr(ovc_pkg::OFF_BLEND, blend(3'h5, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, SEC);
    pix(1'b1, 1'b0, PRI);
    // keyed format with colour keying on: the key compare is skipped, primary stays opaque
    wr(ovc_pkg::OFF_KEY_CTRL, 32'h1000_0000 | {8'h00, 24'h9F_7F_7F});
    pix(1'b0, 1'b0, PRI);
    wr(ovc_pkg::OFF_BLEND, blend(3'h4, 3'h0, 3'h0));
    vs();
    pix(1'b0, 1'b0, PRI);
    final_report();
  end
endmodule
`default_nettype wire
